// ===== pkg/wdt_pkg.sv
// Constants shared by the watchdog fail-safe timer
package wdt_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_CONTROL_ONE = 5'h00;  // watchdog_control_one, write only
    localparam logic [4:0] OFS_CODE        = 5'h04;  // watchdog_code_register, write only
    localparam logic [4:0] OFS_STATUS      = 5'h08;  // Sticky event flags, write one to clear
    localparam logic [4:0] OFS_MASK        = 5'h0C;  // Interrupt mask, same layout as status
    localparam logic [4:0] OFS_STATE       = 5'h10;  // Live state, read only

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_ACTION   = 0;   // overflow_action_select
    localparam int BIT_TSEL_LO  = 1;   // detection_time_select low bit
    localparam int BIT_ENABLE   = 3;   // watchdog_enable_bit
    localparam int BIT_EV_OVF   = 0;   // Status: overflow seen
    localparam int BIT_EV_RSTRQ = 1;   // Status: overflow routed to reset

    // ------------------------------------------------------------------
    // Codes and values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] CODE_CLEAR    = 8'h4E;
    localparam logic [7:0] CODE_DISABLE  = 8'hB1;
    localparam logic       RST_ACTION    = 1'h1;   // Reset request
    localparam logic       RST_ENABLE    = 1'h1;   // Running out of reset
    localparam logic [1:0] RST_TSEL      = 2'h0;
    localparam logic [1:0] RST_STATUS    = 2'h0;
    localparam logic [1:0] RST_MASK      = 2'h0;

    // ------------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------------
    localparam int         FC_TICK_LOG2  = 23;     // Stage tick for code 00, fast clock
    localparam int         FS_TICK_LOG2  = 15;     // Stage tick for code 00, slow clock
    localparam logic [3:0] RST_PULSE_CYC = 4'h8;   // Cycles the reset pin is pulled low

endpackage : wdt_pkg

// ===== rtl/wdt_fail_safe.sv
// Watchdog fail-safe timer with Avalon-MM register access
// Function
// - Overflow action programmable once, resets to reset
// - Watchdog runs automatically after reset release
// - Counter overflow asserts the watchdog output
// - Action one: overflow pulls reset pin low
// - Action zero: overflow raises watchdog interrupt
// - Count frozen in stop, idle, sleep
// - Free prescaler feeding two-stage binary counter
// - Clear code resets binary stages, not prescaler
// - Overflow may come after three quarters time
// - Code 10 gives 2^21 fast cycles
// - Overflow usable as periodic interrupt source
// - Four codes select fast or slow periods
// - Disable code accepted only with enable zero
// - Binary counter held cleared while disabled
// - Watchdog interrupt non-maskable, always accepted
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
module wdt_fail_safe #(
    parameter int FC_LOG2 = wdt_pkg::FC_TICK_LOG2,  // Fast-clock stage tick exponent
    parameter int FS_LOG2 = wdt_pkg::FS_TICK_LOG2   // Slow-clock stage tick exponent
) (
    input  wire logic        i_mclk,                      // 250 MHz fast clock
    input  wire logic        i_rst,                       // Synchronous reset, high
    input  wire logic [4:0]  i_avs_address,               // Byte address
    input  wire logic        i_avs_read,                  // Read request
    input  wire logic        i_avs_write,                 // Write request
    input  wire logic [31:0] i_avs_writedata,             // Write data
    input  wire logic [3:0]  i_avs_byteenable,            // Byte lanes
    output logic      [31:0] o_avs_readdata,              // Read data, registered
    output logic             o_avs_waitrequest,           // Stall
    input  wire logic        i_prescaler_clock_select,    // 1: count slow clock
    input  wire logic        i_slow_mode,                 // Slow operating mode
    input  wire logic        i_low_power_hold,            // Stop, warm-up, idle or sleep
    input  wire logic        i_low_freq_clock,            // Slow clock pin, asynchronous
    output logic             o_reset_pin_o,               // Reset pin drive value
    output logic             o_reset_pin_oe_n,            // Low while pulling reset low
    output logic             o_watchdog_interrupt_request,// Non-maskable pulse
    output logic             o_irq                        // Masked status interrupt
);
    import wdt_pkg::*;

    localparam int PRE_W = (FC_LOG2 > FS_LOG2) ? FC_LOG2 : FS_LOG2;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic             ack_r;
    logic             wr_fire;
    logic             rd_fire;
    logic [7:0]       wbyte;

    // One wait cycle per access, so read data always comes from a flop
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
        end
    end

    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
    assign wr_fire           = i_avs_write & ack_r & i_avs_byteenable[0];
    assign rd_fire           = i_avs_read & ~ack_r;
    assign wbyte             = i_avs_writedata[7:0];

    // Write strobes per register
    logic wr_ctrl;
    logic wr_code;
    logic wr_status;
    logic wr_mask;

    assign wr_ctrl   = wr_fire && (i_avs_address == OFS_CONTROL_ONE);
    assign wr_code   = wr_fire && (i_avs_address == OFS_CODE);
    assign wr_status = wr_fire && (i_avs_address == OFS_STATUS);
    assign wr_mask   = wr_fire && (i_avs_address == OFS_MASK);

    logic clr_cmd;
    logic dis_cmd;

    assign clr_cmd = wr_code && (wbyte == CODE_CLEAR);
    assign dis_cmd = wr_code && (wbyte == CODE_DISABLE);

    // ------------------------------------------------------------------
    // Control register one
    // ------------------------------------------------------------------
    logic       action_r;
    logic       enable_r;
    logic [1:0] tsel_r;

    // Action may only go from reset-request to interrupt, never back
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            action_r <= RST_ACTION;
            enable_r <= RST_ENABLE;
            tsel_r   <= RST_TSEL;
        end else if (wr_ctrl) begin
            action_r <= action_r & wbyte[BIT_ACTION];
            enable_r <= wbyte[BIT_ENABLE];
            tsel_r   <= wbyte[BIT_TSEL_LO +: 2];
        end
    end

    // ------------------------------------------------------------------
    // Running state
    // ------------------------------------------------------------------
    logic running_r;

    // Clearing the enable bit alone stops nothing; the disable code does
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            running_r <= RST_ENABLE;
        end else if (wr_ctrl && wbyte[BIT_ENABLE]) begin
            running_r <= 1'b1;
        end else if (dis_cmd && !enable_r) begin
            running_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Slow clock pin synchroniser and edge detect
    // ------------------------------------------------------------------
    logic fs_meta_r;
    logic fs_sync_r;
    logic fs_prev_r;
    logic fs_edge;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            fs_meta_r <= 1'b0;
            fs_sync_r <= 1'b0;
            fs_prev_r <= 1'b0;
        end else begin
            fs_meta_r <= i_low_freq_clock;
            fs_sync_r <= fs_meta_r;
            fs_prev_r <= fs_sync_r;
        end
    end

    assign fs_edge = fs_sync_r & ~fs_prev_r;

    // ------------------------------------------------------------------
    // Prescaler and stage tick
    // ------------------------------------------------------------------
    // Low-order mask selecting the prescaler tap for a given exponent
    function automatic logic [PRE_W-1:0] tap_mask(input int unsigned lg);
        logic [PRE_W-1:0] m;
        m = '0;
        for (int i = 0; i < PRE_W; i++) begin
            if (i < lg) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : tap_mask

    logic             use_fs;
    logic             src_inc;
    logic [PRE_W-1:0] pre_r;
    logic [PRE_W-1:0] pre_mask;
    logic             tick;

    assign use_fs   = i_prescaler_clock_select | i_slow_mode;
    assign src_inc  = (use_fs ? fs_edge : 1'b1) & ~i_low_power_hold;
    assign pre_mask = use_fs ? tap_mask(FS_LOG2 - 2 * tsel_r)
                             : tap_mask(FC_LOG2 - 2 * tsel_r);
    assign tick     = src_inc && ((pre_r & pre_mask) == pre_mask);

    // Free-running; never touched by the clear code
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pre_r <= '0;
        end else if (src_inc) begin
            pre_r <= pre_r + PRE_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Two-stage binary counter
    // ------------------------------------------------------------------
    logic [1:0] cnt_r;
    logic       ovf;

    // Four stage ticks per detection time; a clear lands anywhere inside the
    // first tick period, hence overflow as early as three quarters after it
    assign ovf = running_r && tick && (cnt_r == 2'h3) && !clr_cmd;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cnt_r <= 2'h0;
        end else if (!running_r || clr_cmd) begin
            cnt_r <= 2'h0;
        end else if (dis_cmd && !enable_r) begin
            cnt_r <= 2'h0;
        end else if (tick) begin
            cnt_r <= cnt_r + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Overflow routing
    // ------------------------------------------------------------------
    logic [3:0] rst_cnt_r;
    logic       nmi_r;

    // Reset request holds the pin low for a fixed number of cycles
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rst_cnt_r <= 4'h0;
        end else if (ovf && action_r) begin
            rst_cnt_r <= RST_PULSE_CYC;
        end else if (rst_cnt_r != 4'h0) begin
            rst_cnt_r <= rst_cnt_r - 4'h1;
        end
    end

    assign o_reset_pin_o    = 1'b0;
    assign o_reset_pin_oe_n = (rst_cnt_r == 4'h0);

    // Interrupt pulse bypasses the mask and any master flag
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            nmi_r <= 1'b0;
        end else begin
            nmi_r <= ovf && !action_r;
        end
    end

    assign o_watchdog_interrupt_request = nmi_r;

    // ------------------------------------------------------------------
    // Status and mask
    // ------------------------------------------------------------------
    logic [1:0] status_r;
    logic [1:0] mask_r;
    logic [1:0] ev_set;

    assign ev_set = {ovf && action_r, ovf};

    // Set wins over a simultaneous write-one-to-clear
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            status_r <= RST_STATUS;
        end else begin
            status_r <= (status_r & ~(wr_status ? wbyte[1:0] : 2'h0)) | ev_set;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            mask_r <= RST_MASK;
        end else if (wr_mask) begin
            mask_r <= wbyte[1:0];
        end
    end

    assign o_irq = |(status_r & mask_r);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Control and code registers are write only and read as zero
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_avs_readdata <= 32'h0;
        end else if (rd_fire) begin
            case (i_avs_address)
                OFS_STATUS: o_avs_readdata <= {30'h0, status_r};
                OFS_MASK:   o_avs_readdata <= {30'h0, mask_r};
                OFS_STATE:  o_avs_readdata <= {25'h0, cnt_r, tsel_r, action_r,
                                               enable_r, running_r};
                default:    o_avs_readdata <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    chk_action_once: assert property (!action_r |=> !action_r)
        else $error("overflow action returned to reset request");

    chk_reset_release: assert property (@(posedge i_mclk) disable iff (1'b0)
        i_rst |=> (action_r && running_r && cnt_r == 2'h0))
        else $error("watchdog not armed after reset");

    chk_ovf_single: assert property (ovf |=> !ovf)
        else $error("overflow longer than one cycle");

    chk_ovf_restart: assert property (ovf |=> cnt_r == 2'h0)
        else $error("counter did not restart after overflow");

    chk_reset_route: assert property (ovf && action_r
        |=> (!o_reset_pin_oe_n)[*8] ##1 o_reset_pin_oe_n)
        else $error("reset pin pulse length wrong");

    chk_nmi_route: assert property (ovf
        |=> o_watchdog_interrupt_request == !$past(action_r))
        else $error("interrupt routing wrong");

    chk_hold_freeze: assert property (i_low_power_hold |=> $stable(pre_r))
        else $error("prescaler moved during hold");

    chk_clear_stages: assert property (clr_cmd
        |=> cnt_r == 2'h0 && pre_r == $past(pre_r) + PRE_W'($past(src_inc)))
        else $error("clear code handled wrong");

    chk_disabled_zero: assert property (!running_r |=> cnt_r == 2'h0)
        else $error("counter moved while disabled");

    chk_disable_gate: assert property (dis_cmd && enable_r && running_r
        |=> running_r)
        else $error("disable code accepted with enable set");

    chk_irq_level: assert property (ovf && mask_r[BIT_EV_OVF] && !wr_mask
        |=> o_irq)
        else $error("masked interrupt missing");

    // Event flags and pin guards; a clear in the same cycle must not hide a set
    chk_status_set: assert property (ovf |=> status_r[BIT_EV_OVF])
        else $error("overflow flag not set");

    chk_status_route: assert property (ovf && action_r |=> status_r[BIT_EV_RSTRQ])
        else $error("reset route flag not set");

    chk_status_clear: assert property (wr_status && wbyte[BIT_EV_OVF] && !ovf
        |=> !status_r[BIT_EV_OVF])
        else $error("overflow flag not cleared");

    chk_pin_quiet: assert property (rst_cnt_r == 4'h0 && !(ovf && action_r)
        |=> o_reset_pin_oe_n)
        else $error("reset pin pulled without overflow");

    // Hold must freeze the stages too, not only the prescaler
    chk_hold_stages: assert property (i_low_power_hold && running_r && !wr_code
        |=> $stable(cnt_r))
        else $error("counter moved during hold");

    // Read data must stand until the next accepted read
    chk_rdata_stands: assert property (!rd_fire |=> $stable(o_avs_readdata))
        else $error("read data changed without a read");

endmodule : wdt_fail_safe

// ===== verif/tb_top.sv
// Self-checking testbench for the watchdog fail-safe timer
`timescale 1ns/1ns
module tb_top;
    import wdt_pkg::*;
    // ----
    // Signals
    // ----
    localparam int FCL = 8;  // Short fast tick so periods stay small
    localparam int FSL = 7;  // Slow tick one above the smallest the design allows (6)
    logic        clk, rst, rd, wr, sel, slow, hold, lfc;
    logic [4:0]  addr;
    logic [31:0] wdata, rdata, q;
    logic [3:0]  be;
    logic [2:0]  div;
    logic        waitreq, pin_o, pin_oe_n, nmi, irq;
    int          miscompares, total_checks, low_cnt, nmi_cnt, cyc;

    wdt_fail_safe #(.FC_LOG2(FCL), .FS_LOG2(FSL)) wdt_fail_safe_inst (
        .i_mclk(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_prescaler_clock_select(sel), .i_slow_mode(slow),
        .i_low_power_hold(hold), .i_low_freq_clock(lfc), .o_reset_pin_o(pin_o),
        .o_reset_pin_oe_n(pin_oe_n), .o_watchdog_interrupt_request(nmi), .o_irq(irq));

    // ----
    // Clocks and monitors
    // ----
    // Fast clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Slow clock, one rising edge every 8 fast cycles
    always @(posedge clk) begin
        div <= div + 3'h1;
        lfc <= div[2];
    end
    // Count reset-pin low cycles and interrupt pulses
    always @(negedge clk) begin
        if (pin_oe_n === 1'b0) low_cnt++;
        if (nmi === 1'b1) nmi_cnt++;
    end

    // ----
    // Tasks
    // ----
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask : check_val
    task automatic check_num(input int got, input int lo, input int hi, input string m);
        total_checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("wrong value at %0t: %s got %0d", $time, m, got);
        end
    endtask : check_num
    // One access, held until waitrequest is seen low at an edge
    task automatic bus(input logic r, input logic [4:0] a, input logic [7:0] d,
                       input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        rd <= r;
        wr <= ~r;
        addr <= a;
        wdata <= {24'h0, d};
        be <= b;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        check_num(n, 2, 2, "bus answer");
    endtask : bus
    task automatic wr8(input logic [4:0] a, input logic [7:0] d);
        bus(1'b0, a, d, 4'h1);
    endtask : wr8
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string m);
        bus(1'b1, a, 8'h00, 4'h1);
        check_val(q, exp, m);
    endtask : rd_chk
    // Wait for a pulse (w=0) or the reset pin pulled low (w=1)
    task automatic wait_sig(input logic w, input int lim);
        cyc = 0;
        do begin
            @(negedge clk);
            cyc++;
        end while ((w ? pin_oe_n !== 1'b0 : nmi !== 1'b1) && cyc < lim);
        check_num(cyc, 1, lim - 1, "wait limit");
        if (!w) begin
            @(negedge clk);
            check_val(nmi, 32'h0, "pulse width");
        end
    endtask : wait_sig
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    // ----
    // Tests
    // ----
    // Watchdog on the bench itself, far beyond the expected run
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
    initial begin
        {rst, rd, wr, sel, slow, hold, lfc} = 7'h40;
        {addr, wdata, be, div} = '0;
        {miscompares, total_checks, low_cnt, nmi_cnt} = '0;
        do_reset();
        rd_chk(OFS_STATE, 32'h07, "state after reset");
        rd_chk(OFS_STATUS, 32'h0, "status after reset");
        rd_chk(OFS_CONTROL_ONE, 32'h0, "control reads zero");
        rd_chk(5'h14, 32'h0, "unmapped");
        bus(1'b0, OFS_MASK, 8'h03, 4'h0);
        rd_chk(OFS_MASK, 32'h0, "mask lane refused");
        // Reset action: steady clears keep the pin quiet, then it falls
        wr8(OFS_CONTROL_ONE, 8'h0F);
        wr8(OFS_CODE, CODE_CLEAR);
        low_cnt = 0;
        repeat (30) wr8(OFS_CODE, CODE_CLEAR);
        check_num(low_cnt, 0, 0, "pin during clears");
        wait_sig(1'b1, 40);
        check_num(cyc, 12, 17, "clear to overflow");
        repeat (12) @(negedge clk);
        check_num(low_cnt, 8, 8, "pin low width");
        check_num(nmi_cnt, 0, 0, "no pulse in reset mode");
        check_val(pin_o, 32'h0, "pin drive level");
        rd_chk(OFS_STATUS, 32'h3, "status reset route");
        do_reset();
        // Interrupt action, then a later write of one is ignored
        wr8(OFS_CONTROL_ONE, 8'h08);
        wr8(OFS_CONTROL_ONE, 8'h09);
        rd_chk(OFS_STATE, 32'h03, "action kept");
        // Period of every selection code, pulses back to back
        for (int t = 0; t < 4; t++) begin
            wr8(OFS_CODE, CODE_CLEAR);
            wr8(OFS_CONTROL_ONE, 8'h08 | 8'(t << 1));
            wr8(OFS_CODE, CODE_CLEAR);
            wait_sig(1'b0, 2000);
            wait_sig(1'b0, 2000);
            check_num(cyc + 1, 1 << (10 - 2 * t), 1 << (10 - 2 * t), "period");
            if (t == 0) begin
                rd_chk(OFS_STATUS, 32'h1, "status interrupt");
                check_val(irq, 32'h0, "irq masked");
                wr8(OFS_MASK, 8'h01);
                @(negedge clk);
                check_val(irq, 32'h1, "irq unmasked");
                wr8(OFS_STATUS, 8'h01);
                rd_chk(OFS_STATUS, 32'h0, "status cleared");
                check_val(irq, 32'h0, "irq cleared");
            end
        end
        // Slow clock source, by selector then by slow mode
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            sel <= (s == 0);
            slow <= (s == 1);
            wait_sig(1'b0, 400);
            wait_sig(1'b0, 400);
            check_num(cyc + 1, 64, 64, "slow period");
        end
        @(posedge clk);
        {sel, slow} <= 2'h0;
        // Hold freezes the count, which then resumes where it stood
        wait_sig(1'b0, 40);
        nmi_cnt = 0;
        @(posedge clk);
        hold <= 1'b1;
        repeat (100) @(posedge clk);
        check_num(nmi_cnt, 0, 0, "held");
        hold <= 1'b0;
        wait_sig(1'b0, 40);
        check_num(cyc, 12, 15, "resume");
        // Disable code refused while enabled, accepted after enable cleared
        wr8(OFS_CODE, CODE_DISABLE);
        bus(1'b1, OFS_STATE, 8'h00, 4'h1);
        check_val(q & 32'h1F, 32'h1B, "disable refused");
        wr8(OFS_CODE, CODE_CLEAR);
        wr8(OFS_CONTROL_ONE, 8'h06);
        wr8(OFS_CODE, CODE_DISABLE);
        nmi_cnt = 0;
        repeat (100) @(posedge clk);
        rd_chk(OFS_STATE, 32'h18, "disabled");
        check_num(nmi_cnt, 0, 0, "quiet while disabled");
        wr8(OFS_CONTROL_ONE, 8'h0E);
        wait_sig(1'b0, 40);
        check_num(cyc, 1, 18, "restart");
        wrap_up();
    end
endmodule : tb_top
